/* design/parallel_ports_pkg.sv */
// register map, field layout and reset values of the parallel ports
`default_nettype none
package parallel_ports_pkg;
    localparam logic [31:0] RED_LIGHT_BASE      = 32'h1000_0000;
    localparam logic [31:0] GREEN_LIGHT_BASE    = 32'h1000_0010;
    localparam logic [31:0] LOW_DIGITS_BASE     = 32'h1000_0020;
    localparam logic [31:0] HIGH_DIGITS_BASE    = 32'h1000_0030;
    localparam logic [31:0] SLIDER_SWITCH_BASE  = 32'h1000_0040;
    localparam logic [31:0] PUSHBUTTON_BASE     = 32'h1000_0050;
    localparam logic [31:0] HEADER_ONE_BASE     = 32'h1000_0060;
    localparam logic [31:0] HEADER_TWO_BASE     = 32'h1000_0070;
    localparam logic [3:0]  DATA_OFFSET         = 4'h0;
    localparam logic [3:0]  DIRECTION_OFFSET    = 4'h4;
    localparam logic [3:0]  MASK_OFFSET         = 4'h8;
    localparam logic [3:0]  EDGE_OFFSET         = 4'hC;
    localparam int          RED_LIGHT_WIDTH     = 18;
    localparam int          GREEN_LIGHT_WIDTH   = 9;
    localparam int          SLIDER_WIDTH        = 18;
    localparam int          PUSHBUTTON_WIDTH    = 3;
    localparam int          HEADER_WIDTH        = 32;
    localparam int          SEGMENT_COUNT       = 7;
    localparam int          DIGITS_PER_REG      = 4;
    localparam int          DIGIT_COUNT         = 8;
    localparam logic [31:0] LIGHT_RESET         = 32'h0000_0000;
    localparam logic [31:0] DIGIT_RESET         = 32'h0000_0000;
    localparam logic [31:0] DIRECTION_RESET     = 32'h0000_0000;
    localparam logic [31:0] PORT_ADDR_MASK      = 32'hFFFF_FFF0;

    // true when the word address falls in the 16-byte window of a port
    function automatic logic port_hit(input logic [31:0] addr, input logic [31:0] base);
        port_hit = (addr & PORT_ADDR_MASK) == base;
    endfunction
endpackage
`default_nettype wire

/* design/output_port.sv */
// write-only output port: data register driving lights or segments
`timescale 1ns/1ps
`default_nettype none
module output_port #(
    parameter int WIDTH = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              wr_en,
    input  wire logic [31:0]       wr_data,
    output logic      [WIDTH-1:0]  pins
);
    // a word write cannot fill a port wider than 32 bits
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("output_port width out of range");
    end

    // bits above the port width are dropped on a word write
    wire logic [WIDTH-1:0] data_d = wr_data[WIDTH-1:0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins <= parallel_ports_pkg::LIGHT_RESET[WIDTH-1:0];
        end else if (wr_en) begin
            pins <= data_d;
        end
    end
endmodule
`default_nettype wire

/* design/bidir_port.sv */
// bidirectional port with data and per-bit direction registers
`timescale 1ns/1ps
`default_nettype none
module bidir_port #(
    parameter int WIDTH = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              data_wr,
    input  wire logic              dir_wr,
    input  wire logic [31:0]       wr_data,
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic      [WIDTH-1:0]  pin_out,
    output logic      [WIDTH-1:0]  pin_oe,
    output logic      [WIDTH-1:0]  data_rd,
    output logic      [WIDTH-1:0]  dir_rd
);
    // data and direction words must fit the 32-bit bus
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("bidir_port width out of range");
    end

    // direction is as wide as data; 1 drives, 0 listens
    wire logic [WIDTH-1:0] out_d = wr_data[WIDTH-1:0];
    wire logic [WIDTH-1:0] dir_d = wr_data[WIDTH-1:0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
        end else if (data_wr) begin
            pin_out <= out_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_oe <= parallel_ports_pkg::DIRECTION_RESET[WIDTH-1:0];
        end else if (dir_wr) begin
            pin_oe <= dir_d;
        end
    end

    // read: pin value for inputs, written value for outputs
    wire logic [WIDTH-1:0] mixed_d = (pin_in & ~pin_oe) | (pin_out & pin_oe);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_rd <= '0;
            dir_rd  <= '0;
        end else begin
            data_rd <= mixed_d;
            dir_rd  <= pin_oe;
        end
    end
endmodule
`default_nettype wire

/* design/parallel_ports.sv */
// memory-mapped parallel ports for lights, digits, switches, buttons, headers
//
// Overview of operation
// - each port: own base, up to four words
// - outputs take writes, inputs return pins
// - direction bit 1 output, 0 input
// - direction register at base plus four
// - 18-bit red light register at 0x10000000
// - nine-bit green light register at 0x10000010
// - upper bits of light writes ignored
// - two digit registers drive digits 3-0, 7-4
// - 18-bit switch register at 0x10000040
// - pushbutton port: three registers from 0x10000050; only the data word is implemented
// - button bits 3-1 reported, bit 0 zero
// - button zero resets the processor system
// - two header ports at 0x10000060, 0x10000070
// - 32 data bits onto header pins
// - bit 0 top-left pin, then rightward
`timescale 1ns/1ps
`default_nettype none
module parallel_ports #(
    parameter int RED_WIDTH    = parallel_ports_pkg::RED_LIGHT_WIDTH,
    parameter int GREEN_WIDTH  = parallel_ports_pkg::GREEN_LIGHT_WIDTH,
    parameter int SWITCH_WIDTH = parallel_ports_pkg::SLIDER_WIDTH,
    parameter int HEADER_WIDTH = parallel_ports_pkg::HEADER_WIDTH
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic [31:0]              bus_addr,
    input  wire logic                     bus_write,
    input  wire logic                     bus_read,
    input  wire logic [31:0]              bus_wdata,
    output logic      [31:0]              bus_rdata,
    output logic                          bus_rvalid,
    output logic      [RED_WIDTH-1:0]     red_lights,
    output logic      [GREEN_WIDTH-1:0]   green_lights,
    output logic      [6:0]               digit_segments [8],
    input  wire logic [SWITCH_WIDTH-1:0]  slider_switches,
    input  wire logic [3:0]               pushbuttons,
    output logic                          system_reset_req,
    input  wire logic [HEADER_WIDTH-1:0]  header_one_in,
    output logic      [HEADER_WIDTH-1:0]  header_one_out,
    output logic      [HEADER_WIDTH-1:0]  header_one_oe,
    input  wire logic [HEADER_WIDTH-1:0]  header_two_in,
    output logic      [HEADER_WIDTH-1:0]  header_two_out,
    output logic      [HEADER_WIDTH-1:0]  header_two_oe
);
    // refuse widths that the 32-bit read and write paths cannot carry
    if (RED_WIDTH < 1 || RED_WIDTH > 32) begin : g_bad_red
        $error("red light width out of range");
    end
    if (GREEN_WIDTH < 1 || GREEN_WIDTH > 32) begin : g_bad_green
        $error("green light width out of range");
    end
    if (SWITCH_WIDTH < 1 || SWITCH_WIDTH > 32) begin : g_bad_switch
        $error("switch width out of range");
    end
    if (HEADER_WIDTH < 1 || HEADER_WIDTH > 32) begin : g_bad_header
        $error("header width out of range");
    end

    // address decode: each port owns a 16-byte window of four words
    wire logic [3:0] word_off  = {bus_addr[3:2], 2'b00};
    wire logic       hit_red   = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::RED_LIGHT_BASE);
    wire logic       hit_green = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::GREEN_LIGHT_BASE);
    wire logic       hit_low   = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::LOW_DIGITS_BASE);
    wire logic       hit_high  = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::HIGH_DIGITS_BASE);
    wire logic       hit_sw    = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::SLIDER_SWITCH_BASE);
    wire logic       hit_key   = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::PUSHBUTTON_BASE);
    wire logic       hit_one   = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::HEADER_ONE_BASE);
    wire logic       hit_two   = parallel_ports_pkg::port_hit(bus_addr,
                                     parallel_ports_pkg::HEADER_TWO_BASE);
    wire logic       at_data   = word_off == parallel_ports_pkg::DATA_OFFSET;
    wire logic       at_dir    = word_off == parallel_ports_pkg::DIRECTION_OFFSET;

    wire logic wr_red   = bus_write && hit_red && at_data;
    wire logic wr_green = bus_write && hit_green && at_data;
    wire logic wr_low   = bus_write && hit_low && at_data;
    wire logic wr_high  = bus_write && hit_high && at_data;
    wire logic wr_one_d = bus_write && hit_one && at_data;
    wire logic wr_one_r = bus_write && hit_one && at_dir;
    wire logic wr_two_d = bus_write && hit_two && at_data;
    wire logic wr_two_r = bus_write && hit_two && at_dir;

    output_port #(.WIDTH(RED_WIDTH)) u_red (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_red),
        .wr_data (bus_wdata),
        .pins    (red_lights)
    );

    output_port #(.WIDTH(GREEN_WIDTH)) u_green (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_green),
        .wr_data (bus_wdata),
        .pins    (green_lights)
    );

    logic [31:0] low_digits_q;
    logic [31:0] high_digits_q;

    output_port #(.WIDTH(32)) u_low (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_low),
        .wr_data (bus_wdata),
        .pins    (low_digits_q)
    );

    output_port #(.WIDTH(32)) u_high (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_high),
        .wr_data (bus_wdata),
        .pins    (high_digits_q)
    );

    // digit n takes byte lane n mod 4; bit 7 of each lane is left unused
    function automatic logic [6:0] lane_segments(input logic [31:0] word, input int lane);
        lane_segments = word[8*lane +: parallel_ports_pkg::SEGMENT_COUNT];
    endfunction

    assign digit_segments[0] = lane_segments(low_digits_q, 0);
    assign digit_segments[1] = lane_segments(low_digits_q, 1);
    assign digit_segments[2] = lane_segments(low_digits_q, 2);
    assign digit_segments[3] = lane_segments(low_digits_q, 3);
    assign digit_segments[4] = lane_segments(high_digits_q, 0);
    assign digit_segments[5] = lane_segments(high_digits_q, 1);
    assign digit_segments[6] = lane_segments(high_digits_q, 2);
    assign digit_segments[7] = lane_segments(high_digits_q, 3);

    logic [HEADER_WIDTH-1:0] one_data_rd;
    logic [HEADER_WIDTH-1:0] one_dir_rd;
    logic [HEADER_WIDTH-1:0] two_data_rd;
    logic [HEADER_WIDTH-1:0] two_dir_rd;

    // bit i maps to pin i of the header, counted from top-left rightward
    bidir_port #(.WIDTH(HEADER_WIDTH)) u_one (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .data_wr (wr_one_d),
        .dir_wr  (wr_one_r),
        .wr_data (bus_wdata),
        .pin_in  (header_one_in),
        .pin_out (header_one_out),
        .pin_oe  (header_one_oe),
        .data_rd (one_data_rd),
        .dir_rd  (one_dir_rd)
    );

    bidir_port #(.WIDTH(HEADER_WIDTH)) u_two (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .data_wr (wr_two_d),
        .dir_wr  (wr_two_r),
        .wr_data (bus_wdata),
        .pin_in  (header_two_in),
        .pin_out (header_two_out),
        .pin_oe  (header_two_oe),
        .data_rd (two_data_rd),
        .dir_rd  (two_dir_rd)
    );

    // button zero is the reset source, never reported in the data word
    logic [3:0] buttons_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            buttons_q <= 4'h0;
        end else begin
            buttons_q <= {pushbuttons[3:1], 1'b0};
        end
    end

    // button zero held down asks for a reset of the processor system
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            system_reset_req <= 1'b0;
        end else begin
            system_reset_req <= pushbuttons[0];
        end
    end

    logic [SWITCH_WIDTH-1:0] switches_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            switches_q <= '0;
        end else begin
            switches_q <= slider_switches;
        end
    end

    // read select: one source per readable word; the windows never overlap
    wire logic sel_sw    = hit_sw && at_data;
    wire logic sel_key   = hit_key && at_data;
    wire logic sel_one_d = hit_one && at_data;
    wire logic sel_one_r = hit_one && at_dir;
    wire logic sel_two_d = hit_two && at_data;
    wire logic sel_two_r = hit_two && at_dir;

    // sources zero-extended to a word; write-only and unmapped words read as zero
    wire logic [31:0] sw_word    = 32'(switches_q);
    wire logic [31:0] key_word   = 32'(buttons_q);
    wire logic [31:0] one_d_word = 32'(one_data_rd);
    wire logic [31:0] one_r_word = 32'(one_dir_rd);
    wire logic [31:0] two_d_word = 32'(two_data_rd);
    wire logic [31:0] two_r_word = 32'(two_dir_rd);
    wire logic [31:0] rdata_d    = ({32{sel_sw}} & sw_word)
                                 | ({32{sel_key}} & key_word)
                                 | ({32{sel_one_d}} & one_d_word)
                                 | ({32{sel_one_r}} & one_r_word)
                                 | ({32{sel_two_d}} & two_d_word)
                                 | ({32{sel_two_r}} & two_r_word);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata  <= 32'h0000_0000;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata  <= bus_read ? rdata_d : 32'h0000_0000;
            bus_rvalid <= bus_read;
        end
    end
endmodule
`default_nettype wire

/* verif/parallel_ports_props.sv */
// concurrent checks on the parallel ports bus and pins
`timescale 1ns/1ps
`default_nettype none
module parallel_ports_props #(
    parameter int RED_WIDTH    = 18,
    parameter int GREEN_WIDTH  = 9,
    parameter int SWITCH_WIDTH = 18,
    parameter int HEADER_WIDTH = 32
) (
    input wire logic                    ref_clk,
    input wire logic                    sys_rst,
    input wire logic [31:0]             bus_addr,
    input wire logic                    bus_write,
    input wire logic                    bus_read,
    input wire logic [31:0]             bus_wdata,
    input wire logic [31:0]             bus_rdata,
    input wire logic                    bus_rvalid,
    input wire logic [RED_WIDTH-1:0]    red_lights,
    input wire logic [GREEN_WIDTH-1:0]  green_lights,
    input wire logic [6:0]              digit_segments [8],
    input wire logic [SWITCH_WIDTH-1:0] slider_switches,
    input wire logic [3:0]              pushbuttons,
    input wire logic                    system_reset_req,
    input wire logic [HEADER_WIDTH-1:0] header_one_out,
    input wire logic [HEADER_WIDTH-1:0] header_one_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr(logic [31:0] a);
        bus_write && bus_addr == a;
    endsequence
    sequence s_rd(logic [31:0] a);
        bus_read && bus_addr == a;
    endsequence
    chk_read_answer: assert property (bus_read |=> bus_rvalid)
        else $error("read not answered");
    chk_idle_quiet: assert property (!bus_read |=> !bus_rvalid && bus_rdata == 32'h0)
        else $error("read answer without read");
    chk_red_write: assert property (s_wr(32'h1000_0000) |=>
        red_lights == $past(bus_wdata[RED_WIDTH-1:0])) else $error("red lights wrong");
    chk_green_write: assert property (s_wr(32'h1000_0010) |=>
        green_lights == $past(bus_wdata[GREEN_WIDTH-1:0])) else $error("green lights wrong");
    chk_digit_lanes: assert property (s_wr(32'h1000_0030) |=>
        digit_segments[4] == $past(bus_wdata[6:0]) && digit_segments[7] == $past(bus_wdata[30:24]))
        else $error("digit lanes wrong");
    chk_switch_read: assert property (s_rd(32'h1000_0040) |=>
        bus_rdata == 32'($past(slider_switches, 2))) else $error("switch read wrong");
    chk_button_read: assert property (s_rd(32'h1000_0050) |=>
        bus_rdata == {28'h0, $past(pushbuttons[3:1], 2), 1'b0}) else $error("button read wrong");
    chk_reset_button: assert property (pushbuttons[0] ##1 pushbuttons[0] |-> system_reset_req)
        else $error("reset button ignored");
    chk_dir_write: assert property (s_wr(32'h1000_0064) |=>
        header_one_oe == $past(bus_wdata[HEADER_WIDTH-1:0])) else $error("direction wrong");
    chk_header_out: assert property (s_wr(32'h1000_0060) |=>
        header_one_out == $past(bus_wdata[HEADER_WIDTH-1:0])) else $error("header out wrong");
    chk_unused_word: assert property (s_rd(32'h1000_0068) |=> bus_rdata == 32'h0)
        else $error("unused word not zero");
endmodule
bind parallel_ports parallel_ports_props #(.RED_WIDTH(RED_WIDTH), .GREEN_WIDTH(GREEN_WIDTH),
    .SWITCH_WIDTH(SWITCH_WIDTH), .HEADER_WIDTH(HEADER_WIDTH)) u_props (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_write(bus_write), .bus_read(bus_read),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .red_lights(red_lights), .green_lights(green_lights), .digit_segments(digit_segments),
    .slider_switches(slider_switches), .pushbuttons(pushbuttons),
    .system_reset_req(system_reset_req), .header_one_out(header_one_out),
    .header_one_oe(header_one_oe));
`default_nettype wire

/* verif/cpu_model.sv */
// processor model issuing word stores and loads
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic        ref_clk,
    output logic      [31:0] bus_addr,
    output logic             bus_write,
    output logic             bus_read,
    output logic      [31:0] bus_wdata,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_rvalid
);
    initial begin
        bus_addr = 32'h0;
        bus_write = 1'b0;
        bus_read = 1'b0;
        bus_wdata = 32'h0;
    end
    // released data shows the inverse so stale values are never mistaken
    task automatic store(input logic [31:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_write = 1'b1;
        @(negedge ref_clk);
        bus_write = 1'b0;
        bus_wdata = ~d;
        bus_addr = ~a;
    endtask
    task automatic load(input logic [31:0] a, output logic [31:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_read = 1'b1;
        @(negedge ref_clk);
        bus_read = 1'b0;
        bus_addr = ~a;
        d = bus_rvalid ? bus_rdata : 32'hBAD0_BAD0;
    endtask
endmodule
`default_nettype wire

/* verif/test_memory_mapped_parallel_ports.sv */
// self-checking bench for the memory-mapped parallel ports
`timescale 1ns/1ps
`default_nettype none
module test_memory_mapped_parallel_ports;
    logic        ref_clk, sys_rst, bus_write, bus_read, bus_rvalid, system_reset_req;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, h1_ext, h2_ext;
    logic [31:0] h1_in, h1_out, h1_oe, h2_in, h2_out, h2_oe;
    logic [17:0] red_lights, slider_switches;
    logic [8:0]  green_lights;
    logic [6:0]  digit_segments [8];
    logic [3:0]  pushbuttons;
    int          errors, compares;
    assign h1_in = (h1_oe & h1_out) | (~h1_oe & h1_ext);
    assign h2_in = (h2_oe & h2_out) | (~h2_oe & h2_ext);
    parallel_ports u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_write(bus_write), .bus_read(bus_read), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .red_lights(red_lights),
        .green_lights(green_lights), .digit_segments(digit_segments),
        .slider_switches(slider_switches), .pushbuttons(pushbuttons),
        .system_reset_req(system_reset_req), .header_one_in(h1_in), .header_one_out(h1_out),
        .header_one_oe(h1_oe), .header_two_in(h2_in), .header_two_out(h2_out),
        .header_two_oe(h2_oe));
    cpu_model u_cpu (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_write(bus_write),
        .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("oe1", h1_oe, 32'h0);
        check("oe2", h2_oe, 32'h0);
        sys_rst = 1'b0;
    endtask
    task automatic t_lights;
        logic [31:0] d;
        u_cpu.store(32'h1000_0000, 32'hFFFF_FFFF);
        u_cpu.store(32'h1000_0010, 32'hFFFF_FE5A);
        check("red", 32'(red_lights), 32'h0003_FFFF);
        check("green", 32'(green_lights), 32'h0000_005A);
        u_cpu.load(32'h1000_0000, d);
        check("red read", d, 32'h0);
    endtask
    task automatic t_digits;
        logic [31:0] w;
        u_cpu.store(32'h1000_0020, 32'hCFDB_86FF);
        u_cpu.store(32'h1000_0030, 32'h8066_6D7D);
        for (int i = 0; i < 8; i++) begin
            w = (i < 4) ? 32'hCFDB_86FF : 32'h8066_6D7D;
            check("digit", 32'(digit_segments[i]), (w >> (8 * (i % 4))) & 32'h7F);
        end
    endtask
    task automatic t_switches;
        logic [31:0] d;
        slider_switches = 18'h2_A5A5;
        repeat (3) @(negedge ref_clk);
        u_cpu.load(32'h1000_0040, d);
        check("switches", d, 32'h0002_A5A5);
        u_cpu.store(32'h1000_0040, 32'h0);
        u_cpu.load(32'h1000_0040, d);
        check("switches ro", d, 32'h0002_A5A5);
    endtask
    task automatic t_buttons;
        logic [31:0] d;
        pushbuttons = 4'hB;
        repeat (3) @(negedge ref_clk);
        u_cpu.load(32'h1000_0050, d);
        check("buttons", d, 32'h0000_000A);
        check("reset req", 32'(system_reset_req), 32'h1);
        u_cpu.load(32'h1000_0058, d);
        check("button word", d, 32'h0);
        pushbuttons = 4'h0;
        repeat (2) @(negedge ref_clk);
        check("reset req", 32'(system_reset_req), 32'h0);
    endtask
    task automatic t_header(input int n);
        logic [31:0] base, w, d, ext;
        base = n ? 32'h1000_0070 : 32'h1000_0060;
        w = n ? 32'h8765_4321 : 32'h1234_5678;
        ext = n ? 32'h3C5A_F069 : 32'hA5C3_0F96;
        if (n) h2_ext = ext;
        else h1_ext = ext;
        u_cpu.store(base + 32'h4, 32'h0000_FFFF);
        u_cpu.store(base, w);
        check("oe", n ? h2_oe : h1_oe, 32'h0000_FFFF);
        check("out", (n ? h2_out : h1_out) & 32'hFFFF, w & 32'hFFFF);
        repeat (2) @(negedge ref_clk);
        u_cpu.load(base, d);
        check("data", d, (w & 32'hFFFF) | (ext & 32'hFFFF_0000));
        u_cpu.load(base + 32'h4, d);
        check("dir", d, 32'h0000_FFFF);
        u_cpu.load(base + 32'h8, d);
        check("unused", d, 32'h0);
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        errors++;
        test_done;
    end
    initial begin
        sys_rst = 1'b1;
        slider_switches = 18'h0;
        pushbuttons = 4'h0;
        h1_ext = 32'h0;
        h2_ext = 32'h0;
        t_reset;
        t_lights;
        t_digits;
        t_switches;
        t_buttons;
        t_header(0);
        t_header(1);
        t_reset;
        test_done;
    end
endmodule
`default_nettype wire
